// file: hdl/gain_blc_regs.sv
// gain and black level calibration register bank of the image sensor
//
// How it works
// - four channel gain registers, seven bits each
// - gains reset to 0x08, unity gain
// - all-channel write loads all four gains
// - all-channel read returns first green gain
// - floor threshold bits 5-0, reset 29
// - ceiling threshold bits 14-8, reset 35
// - bit 7 set uses programmed thresholds
// - bit 15 reloads maximum after restart
// - both clear: ceiling equals floor plus five
// - bit 15 resets to one
// - first green offset, nine bits at 0x60
// - second green offset at 0x61
// - offsets are sign-magnitude, bit 8 sign
// - restart bit starts sweep, self-clears
// - gains apply at frame edge unless held
`timescale 1ns/1ps
`default_nettype none

`include "gain_blc_defines.svh"

module gain_blc_regs
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port from the serial interface engine
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rdata_vld,
    // frame timing
    input wire logic frame_start,
    // black level loop interface
    input wire logic blc_max_adj_vld,
    input wire logic [6:0] blc_max_adj,
    output logic blc_restart,
    output logic [6:0] blc_max,
    output logic [5:0] black_floor_threshold,
    output logic [6:0] black_ceiling_threshold,
    // values handed to the analog path
    output gain_blc_pkg::gain_set_t gain_live,
    output gain_blc_pkg::offset_pair_t offset_live
);
    import gain_blc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // decoding helpers

    // a gain word keeps only its seven code bits
    function automatic logic [6:0] gain_field(input logic [15:0] w);
        gain_field = w[`GAIN_W-1:0];
    endfunction

    // widen a stored gain code for a read
    function automatic logic [15:0] gain_word(input logic [6:0] g);
        gain_word = {9'h000, g};
    endfunction

    // widen a stored offset value for a read
    function automatic logic [15:0] ofs_word(input logic [8:0] o);
        ofs_word = {7'h00, o};
    endfunction

    // which ceiling policy the control bits pick
    function automatic ceil_mode_t ceil_mode(input thres_reg_t t);
        if (t.manual)
        begin
            ceil_mode = CEIL_MANUAL;
        end
        else if (t.no_gain_dep)
        begin
            ceil_mode = CEIL_RELOAD;
        end
        else
        begin
            ceil_mode = CEIL_AUTO;
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // write decode

    logic wr_g1; // first green gain write
    logic wr_blue; // blue gain write
    logic wr_red; // red gain write
    logic wr_g2; // second green gain write
    logic wr_all; // all-channel alias write
    logic wr_thres; // threshold register write
    logic wr_ofs1; // first green offset write
    logic wr_ofs2; // second green offset write
    logic wr_ctrl; // black level control write
    logic wr_sync; // write synchronise register write

    // one strobe per register; no side effects on unmapped writes
    always_comb
    begin
        wr_g1 = reg_wr && (reg_addr == `ADDR_GAIN_G1);
        wr_blue = reg_wr && (reg_addr == `ADDR_GAIN_BLUE);
        wr_red = reg_wr && (reg_addr == `ADDR_GAIN_RED);
        wr_g2 = reg_wr && (reg_addr == `ADDR_GAIN_G2);
        wr_all = reg_wr && (reg_addr == `ADDR_GAIN_ALL);
        wr_thres = reg_wr && (reg_addr == `ADDR_BLC_THRES);
        wr_ofs1 = reg_wr && (reg_addr == `ADDR_OFS_G1);
        wr_ofs2 = reg_wr && (reg_addr == `ADDR_OFS_G2);
        wr_ctrl = reg_wr && (reg_addr == `ADDR_BLC_CTRL);
        wr_sync = reg_wr && (reg_addr == `ADDR_WR_SYNC);
    end

    ////////////////////////////////////////////////////////////////
    // gain registers

    gain_set_t gain_ff; // programmed codes, not yet applied
    gain_set_t nxt_gain;

    // next gain codes; the alias write fans out to all four
    always_comb
    begin
        nxt_gain = gain_ff;
        if (wr_all)
        begin
            // alias has no storage of its own
            nxt_gain.first_green = gain_field(reg_wdata);
            nxt_gain.blue = gain_field(reg_wdata);
            nxt_gain.red = gain_field(reg_wdata);
            nxt_gain.second_green = gain_field(reg_wdata);
        end
        // individual writes, one per channel
        if (wr_g1)
        begin
            nxt_gain.first_green = gain_field(reg_wdata);
        end
        if (wr_blue)
        begin
            nxt_gain.blue = gain_field(reg_wdata);
        end
        if (wr_red)
        begin
            nxt_gain.red = gain_field(reg_wdata);
        end
        if (wr_g2)
        begin
            nxt_gain.second_green = gain_field(reg_wdata);
        end
    end

    // register the gain codes; every channel starts at unity
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            gain_ff.first_green <= `GAIN_RST;
            gain_ff.blue <= `GAIN_RST;
            gain_ff.red <= `GAIN_RST;
            gain_ff.second_green <= `GAIN_RST;
        end
        else
        begin
            gain_ff <= nxt_gain;
        end
    end

    ////////////////////////////////////////////////////////////////
    // threshold register

    thres_reg_t thres_ff; // floor, ceiling and policy bits
    thres_reg_t nxt_thres;

    // next threshold contents; bit 6 is not stored
    always_comb
    begin
        nxt_thres = thres_ff;
        if (wr_thres)
        begin
            nxt_thres.floor = reg_wdata[`THR_FLOOR_MSB:0];
            nxt_thres.manual = reg_wdata[`THR_MANUAL_BIT];
            nxt_thres.ceiling =
                reg_wdata[`THR_CEIL_MSB:`THR_CEIL_LSB];
            nxt_thres.no_gain_dep =
                reg_wdata[`THR_NO_GAIN_DEP_BIT];
        end
    end

    // register thresholds; reset selects manual, gain-independent
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            thres_ff.floor <= `FLOOR_RST;
            thres_ff.manual <= 1'b1;
            thres_ff.ceiling <= `CEIL_RST;
            thres_ff.no_gain_dep <= 1'b1;
        end
        else
        begin
            thres_ff <= nxt_thres;
        end
    end

    ////////////////////////////////////////////////////////////////
    // offset correction values

    offset_pair_t ofs_ff; // sign-magnitude values for both greens
    offset_pair_t nxt_ofs;

    // next offsets; bit 8 is the sign, bits 7-0 the magnitude
    always_comb
    begin
        nxt_ofs = ofs_ff;
        if (wr_ofs1)
        begin
            // stored as written, sign-magnitude kept intact
            nxt_ofs.first_green_offset_value =
                reg_wdata[`OFS_SIGN_BIT:0];
        end
        if (wr_ofs2)
        begin
            nxt_ofs.second_green_offset_value =
                reg_wdata[`OFS_SIGN_BIT:0];
        end
    end

    // register offsets
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ofs_ff <= '{`OFS_RST, `OFS_RST};
        end
        else
        begin
            ofs_ff <= nxt_ofs;
        end
    end

    ////////////////////////////////////////////////////////////////
    // black level restart and write synchronise controls

    logic restart_ff; // one-cycle restart pulse
    logic nxt_restart;
    logic hold_ff; // holds gain updates while set
    logic nxt_hold;

    // restart bit never stores: a written one becomes a pulse
    always_comb
    begin
        nxt_restart = wr_ctrl && reg_wdata[`BLC_RESTART_BIT];
        nxt_hold = hold_ff;
        if (wr_sync)
        begin
            nxt_hold = reg_wdata[`SYNC_HOLD_BIT];
        end
    end

    // register controls
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            restart_ff <= 1'b0;
            hold_ff <= 1'b0;
        end
        else
        begin
            restart_ff <= nxt_restart;
            hold_ff <= nxt_hold;
        end
    end

    ////////////////////////////////////////////////////////////////
    // effective thresholds and black level maximum

    logic [5:0] floor_ff; // floor seen by the loop
    logic [5:0] nxt_floor;
    logic [6:0] ceil_ff; // ceiling seen by the loop
    logic [6:0] nxt_ceil;
    logic [6:0] max_ff; // running black level maximum
    logic [6:0] nxt_max;
    ceil_mode_t mode; // current ceiling policy

    // choose ceiling per policy; the loop may move the maximum
    // only when the policy lets it
    always_comb
    begin
        mode = ceil_mode(thres_ff);
        nxt_floor = thres_ff.floor;
        nxt_ceil = thres_ff.ceiling;
        nxt_max = max_ff;
        case (mode)
            CEIL_MANUAL:
            begin
                // loop adjustments are dropped here
                nxt_ceil = thres_ff.ceiling;
                nxt_max = thres_ff.ceiling;
            end
            CEIL_RELOAD:
            begin
                nxt_ceil = thres_ff.ceiling;
                if (blc_max_adj_vld)
                begin
                    nxt_max = blc_max_adj;
                end
                // restart wins over a same-cycle adjustment
                if (restart_ff)
                begin
                    nxt_max = thres_ff.ceiling;
                end
            end
            CEIL_AUTO:
            begin
                // six-bit floor plus five always fits seven bits
                nxt_ceil = {1'b0, thres_ff.floor}
                    + `CEIL_AUTO_STEP;
                if (blc_max_adj_vld)
                begin
                    nxt_max = blc_max_adj;
                end
                if (restart_ff)
                begin
                    nxt_max = nxt_ceil;
                end
            end
            default:
            begin
                nxt_ceil = thres_ff.ceiling;
                nxt_max = thres_ff.ceiling;
            end
        endcase
    end

    // register effective values
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            floor_ff <= `FLOOR_RST;
            ceil_ff <= `CEIL_RST;
            max_ff <= `CEIL_RST;
        end
        else
        begin
            floor_ff <= nxt_floor;
            ceil_ff <= nxt_ceil;
            max_ff <= nxt_max;
        end
    end

    ////////////////////////////////////////////////////////////////
    // applied gains and offsets

    gain_set_t gain_live_w; // output of the apply stage
    offset_pair_t ofs_live_ff; // offsets follow one cycle behind
    offset_pair_t nxt_ofs_live;

    // gains move to the analog path only at a frame edge
    gain_apply_stage u_apply
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .gain_prog(gain_ff),
        .apply_hold(hold_ff),
        .frame_start(frame_start),
        .gain_live(gain_live_w)
    );

    // offsets are not brightness settings, so they pass straight on
    always_comb
    begin
        nxt_ofs_live = ofs_ff;
    end

    // register offsets for the analog path
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ofs_live_ff <= '{`OFS_RST, `OFS_RST};
        end
        else
        begin
            ofs_live_ff <= nxt_ofs_live;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path

    logic [15:0] rdata_ff; // read word, one cycle after request
    logic [15:0] nxt_rdata;
    logic rvld_ff; // marks the read word
    logic nxt_rvld;

    // read mux; unmapped offsets and write-only bits read zero
    always_comb
    begin
        nxt_rvld = reg_rd;
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_GAIN_G1: nxt_rdata = gain_word(gain_ff.first_green);
                `ADDR_GAIN_BLUE: nxt_rdata = gain_word(gain_ff.blue);
                `ADDR_GAIN_RED: nxt_rdata = gain_word(gain_ff.red);
                `ADDR_GAIN_G2: nxt_rdata = gain_word(gain_ff.second_green);
                // alias reflects the first green store
                `ADDR_GAIN_ALL:
                    nxt_rdata = gain_word(gain_ff.first_green);
                `ADDR_BLC_THRES:
                    nxt_rdata = {thres_ff.no_gain_dep, thres_ff.ceiling,
                        thres_ff.manual, 1'b0, thres_ff.floor};
                `ADDR_OFS_G1:
                    nxt_rdata = ofs_word(ofs_ff.first_green_offset_value);
                `ADDR_OFS_G2:
                    nxt_rdata = ofs_word(ofs_ff.second_green_offset_value);
                // restart bit reads back as zero, it clears itself
                `ADDR_BLC_CTRL: nxt_rdata = 16'h0000;
                `ADDR_WR_SYNC: nxt_rdata = {14'h0000, hold_ff, 1'b0};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // register the read answer
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rdata_ff <= 16'h0000;
            rvld_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvld_ff <= nxt_rvld;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign reg_rdata = rdata_ff;
    assign reg_rdata_vld = rvld_ff;
    assign blc_restart = restart_ff;
    assign blc_max = max_ff;
    assign black_floor_threshold = floor_ff;
    assign black_ceiling_threshold = ceil_ff;
    assign gain_live = gain_live_w;
    assign offset_live = ofs_live_ff;

endmodule

`default_nettype wire

// file: inc/gain_blc_defines.svh
// offsets, field positions, reset values and the automatic ceiling step of the gain bank
`ifndef GAIN_BLC_DEFINES_SVH
`define GAIN_BLC_DEFINES_SVH

// register offsets on the serial register port
`define ADDR_GAIN_G1 8'h2b
`define ADDR_GAIN_BLUE 8'h2c
`define ADDR_GAIN_RED 8'h2d
`define ADDR_GAIN_G2 8'h2e
`define ADDR_GAIN_ALL 8'h35
`define ADDR_BLC_THRES 8'h5f
`define ADDR_OFS_G1 8'h60
`define ADDR_OFS_G2 8'h61
`define ADDR_BLC_CTRL 8'h62
`define ADDR_WR_SYNC 8'hf1

// field widths
`define GAIN_W 7
`define FLOOR_W 6
`define CEIL_W 7
`define OFS_W 9

// threshold register field positions
`define THR_FLOOR_MSB 5
`define THR_MANUAL_BIT 7
`define THR_CEIL_LSB 8
`define THR_CEIL_MSB 14
`define THR_NO_GAIN_DEP_BIT 15
// offset value sign position
`define OFS_SIGN_BIT 8
// black level control restart bit
`define BLC_RESTART_BIT 12
// write synchronise hold bit
`define SYNC_HOLD_BIT 1

// reset values
`define GAIN_RST 7'h08
`define FLOOR_RST 6'h1d
`define CEIL_RST 7'h23
`define OFS_RST 9'h000
// automatic ceiling distance above the floor
`define CEIL_AUTO_STEP 7'h05

`endif

// file: inc/gain_blc_pkg.sv
// types shared by the gain and black level register bank
package gain_blc_pkg;

    // one gain code for each bayer colour
    typedef struct packed {
        logic [6:0] first_green;
        logic [6:0] blue;
        logic [6:0] red;
        logic [6:0] second_green;
    } gain_set_t;

    // threshold register contents
    typedef struct packed {
        logic no_gain_dep;
        logic [6:0] ceiling;
        logic manual;
        logic [5:0] floor;
    } thres_reg_t;

    // sign-magnitude offset correction values for both greens
    typedef struct packed {
        logic [8:0] first_green_offset_value;
        logic [8:0] second_green_offset_value;
    } offset_pair_t;

    // how the ceiling threshold is governed
    typedef enum logic [1:0] {
        CEIL_MANUAL,
        CEIL_RELOAD,
        CEIL_AUTO
    } ceil_mode_t;

endpackage

// file: hdl/gain_apply_stage.sv
// frame-boundary apply stage for the programmed gain codes
`timescale 1ns/1ps
`default_nettype none

module gain_apply_stage
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // programmed side
    input wire gain_blc_pkg::gain_set_t gain_prog,
    input wire logic apply_hold,
    input wire logic frame_start,
    // applied side
    output var gain_blc_pkg::gain_set_t gain_live
);
    import gain_blc_pkg::*;

    gain_set_t live_ff;
    gain_set_t nxt_live;

    ////////////////////////////////////////////////////////////////
    // next live set: copied only at a frame edge and not held
    always_comb
    begin
        nxt_live = live_ff;
        // a held update waits; pending codes stay in the bank
        if (frame_start && !apply_hold)
        begin
            nxt_live = gain_prog;
        end
    end

    // register the live set
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            live_ff <= '{`GAIN_RST, `GAIN_RST, `GAIN_RST, `GAIN_RST};
        end
        else
        begin
            live_ff <= nxt_live;
        end
    end

    assign gain_live = live_ff;

endmodule

`default_nettype wire

// file: test/gain_blc_regs_properties.sv
// port-level assertions for the gain and black level register bank
`timescale 1ns/1ps
`default_nettype none

module gain_blc_regs_properties
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rdata_vld,
    // frame and loop side
    input wire logic frame_start,
    input wire logic blc_max_adj_vld,
    input wire logic [6:0] blc_max_adj,
    input wire logic blc_restart,
    input wire logic [6:0] blc_max,
    input wire logic [5:0] black_floor_threshold,
    input wire logic [6:0] black_ceiling_threshold,
    // applied values
    input wire gain_blc_pkg::gain_set_t gain_live,
    input wire gain_blc_pkg::offset_pair_t offset_live
);
    import gain_blc_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // any gain register or its alias
    wire logic gain_addr = (reg_addr >= 8'h2b && reg_addr <= 8'h2e)
        || reg_addr == 8'h35;
    // all-channel write, then a clean gain read
    sequence s_all_write;
        reg_wr && reg_addr == 8'h35;
    endsequence
    sequence s_gain_read;
        reg_rd && !reg_wr && gain_addr;
    endsequence
    // restart request on the control register
    sequence s_restart_write;
        reg_wr && reg_addr == 8'h62 && reg_wdata[12];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_read_answer_pulse: assert property (
        reg_rdata_vld == $past(reg_rd && !sys_rst))
        else $error("read valid pulse out of step");
    a_all_gain_load: assert property (
        s_all_write ##1 !reg_wr ##1 s_gain_read
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'h007f))
        else $error("all-channel write missing from a gain");
    a_gain_upper_zero: assert property (
        reg_rd && gain_addr |=> reg_rdata[15:7] == 9'h000)
        else $error("gain upper bits not zero");
    a_offset_upper_zero: assert property (
        reg_rd && (reg_addr == 8'h60 || reg_addr == 8'h61)
        |=> reg_rdata[15:9] == 7'h00)
        else $error("offset upper bits not zero");
    a_restart_pulse: assert property (
        s_restart_write |=> blc_restart ##1 !blc_restart)
        else $error("restart is not a single pulse");
    a_restart_cause: assert property (
        blc_restart |-> $past(reg_wr && reg_addr == 8'h62 && reg_wdata[12]))
        else $error("restart without a request");
    a_restart_reload: assert property (
        blc_restart |=> blc_max == black_ceiling_threshold)
        else $error("maximum not reloaded after restart");
    a_fixed_ceiling: assert property (
        reg_rdata_vld && $past(reg_addr) == 8'h5f
        && (reg_rdata[7] || reg_rdata[15])
        |-> black_ceiling_threshold == reg_rdata[14:8]
        && black_floor_threshold == reg_rdata[5:0])
        else $error("programmed thresholds not in use");
    a_auto_ceiling: assert property (
        reg_rdata_vld && $past(reg_addr) == 8'h5f
        && !reg_rdata[7] && !reg_rdata[15]
        |-> black_ceiling_threshold == {1'b0, reg_rdata[5:0]} + 7'h05)
        else $error("automatic ceiling is not floor plus five");
    // guards keep a fresh write from racing the read word
    a_offset_follow: assert property (
        reg_rdata_vld && $past(reg_addr) == 8'h60
        && !$past(reg_wr) && !$past(reg_wr, 2)
        |-> offset_live.first_green_offset_value == reg_rdata[8:0])
        else $error("first green offset output differs");
    a_gain_hold_frame: assert property (
        !$past(frame_start) && !$past(sys_rst) |-> $stable(gain_live))
        else $error("applied gains moved off a frame edge");
endmodule

bind gain_blc_regs gain_blc_regs_properties gain_blc_regs_properties_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rdata_vld(reg_rdata_vld),
    .frame_start(frame_start), .blc_max_adj_vld(blc_max_adj_vld),
    .blc_max_adj(blc_max_adj), .blc_restart(blc_restart),
    .blc_max(blc_max), .black_floor_threshold(black_floor_threshold),
    .black_ceiling_threshold(black_ceiling_threshold),
    .gain_live(gain_live), .offset_live(offset_live));

`default_nettype wire

// file: test/tb.sv
// self-checking bench for the gain and black level register bank
`timescale 1ns/1ps
`default_nettype none
`include "gain_blc_defines.svh"

module tb;
    import gain_blc_pkg::*;
    // design ports, every input given a value at time zero
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic reg_rdata_vld;
    logic frame_start = 1'b0;
    logic blc_max_adj_vld = 1'b0;
    logic [6:0] blc_max_adj = 7'h00;
    logic blc_restart;
    logic [6:0] blc_max;
    logic [5:0] black_floor_threshold;
    logic [6:0] black_ceiling_threshold;
    gain_set_t gain_live;
    offset_pair_t offset_live;
    // tallies and channel tables
    int n_fail = 0;
    int checked = 0;
    int i;
    logic [7:0] gmap [4] = '{`ADDR_GAIN_G1, `ADDR_GAIN_BLUE, `ADDR_GAIN_RED,
        `ADDR_GAIN_G2};
    logic [6:0] codes [4] = '{7'h10, 7'h20, 7'h55, 7'h67};

    // 10 mhz system clock
    always #50 clk_sys = ~clk_sys;

    gain_blc_regs gain_blc_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_vld(reg_rdata_vld),
        .frame_start(frame_start), .blc_max_adj_vld(blc_max_adj_vld),
        .blc_max_adj(blc_max_adj), .blc_restart(blc_restart),
        .blc_max(blc_max), .black_floor_threshold(black_floor_threshold),
        .black_ceiling_threshold(black_ceiling_threshold),
        .gain_live(gain_live), .offset_live(offset_live));

    ////////////////////////////////////////////////////////////////////////
    // compare one value; four-state so an unknown never matches
    task automatic chk(input string what, input logic [27:0] exp,
        input logic [27:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // let an edge pass, then drive a little after it
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    // write strobe for one cycle, idle cycle after so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask
    // read strobe; the word and its valid pulse stand one cycle later
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        reg_rd = 1'b0;
        chk("read valid", 28'h1, reg_rdata_vld);
        chk("read data", exp, reg_rdata);
        step();
    endtask
    // frame boundary pulse
    task automatic frame();
        frame_start = 1'b1;
        step();
        frame_start = 1'b0;
        step();
    endtask
    // loop adjustment of the black level maximum
    task automatic adjust(input logic [6:0] v);
        blc_max_adj = v;
        blc_max_adj_vld = 1'b1;
        step();
        blc_max_adj_vld = 1'b0;
        step();
    endtask
    // verdict; the only place the run ends
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        // reset contents
        for (i = 0; i < 4; i++)
            rd(gmap[i], 16'h0008);
        rd(`ADDR_GAIN_ALL, 16'h0008);
        rd(`ADDR_BLC_THRES, 16'ha39d);
        rd(`ADDR_OFS_G1, 16'h0000);
        rd(`ADDR_OFS_G2, 16'h0000);
        chk("gains", {4{7'h08}}, gain_live);
        chk("floor", 28'h1d, black_floor_threshold);
        chk("ceiling", 28'h23, black_ceiling_threshold);
        $display("test reset values done");
        // each channel on its own, junk in the unused bits
        for (i = 0; i < 4; i++)
            wr(gmap[i], 16'hff80 | codes[i]);
        for (i = 0; i < 4; i++)
            rd(gmap[i], {9'h000, codes[i]});
        rd(`ADDR_GAIN_ALL, 16'h0010);
        chk("gains", {4{7'h08}}, gain_live);
        frame();
        chk("gains", {codes[0], codes[1], codes[2], codes[3]},
            gain_live);
        $display("test channel gains done");
        // alias loads all four at once
        wr(`ADDR_GAIN_ALL, 16'h0051);
        for (i = 0; i < 4; i++)
            rd(gmap[i], 16'h0051);
        frame();
        chk("gains", {4{7'h51}}, gain_live);
        // hold off applying, then release
        wr(`ADDR_WR_SYNC, 16'h0002);
        wr(`ADDR_GAIN_BLUE, 16'h0060);
        frame();
        chk("held gains", {4{7'h51}}, gain_live);
        wr(`ADDR_WR_SYNC, 16'h0000);
        frame();
        chk("gains", {7'h51, 7'h60, 7'h51, 7'h51}, gain_live);
        $display("test alias and hold done");
        // manual thresholds ignore the loop; bit 6 does not store
        wr(`ADDR_BLC_THRES, 16'hb0ca);
        rd(`ADDR_BLC_THRES, 16'hb08a);
        chk("floor", 28'h0a, black_floor_threshold);
        chk("ceiling", 28'h30, black_ceiling_threshold);
        adjust(7'h40);
        chk("maximum", 28'h30, blc_max);
        // reload mode: adjustments land, restart reloads programmed value
        wr(`ADDR_BLC_THRES, 16'hb010);
        chk("ceiling", 28'h30, black_ceiling_threshold);
        adjust(7'h40);
        chk("maximum", 28'h40, blc_max);
        wr(`ADDR_BLC_CTRL, 16'h1000);
        chk("maximum", 28'h30, blc_max);
        rd(`ADDR_BLC_CTRL, 16'h0000);
        // automatic ceiling five above the floor
        wr(`ADDR_BLC_THRES, 16'h3010);
        rd(`ADDR_BLC_THRES, 16'h3010);
        chk("ceiling", 28'h15, black_ceiling_threshold);
        wr(`ADDR_BLC_CTRL, 16'h1000);
        chk("maximum", 28'h15, blc_max);
        $display("test thresholds done");
        // sign-magnitude offsets, unused bits dropped
        wr(`ADDR_OFS_G1, 16'hff85);
        rd(`ADDR_OFS_G1, 16'h0185);
        wr(`ADDR_OFS_G2, 16'h0123);
        rd(`ADDR_OFS_G2, 16'h0123);
        chk("offsets", {9'h185, 9'h123}, offset_live);
        // unmapped place takes nothing and reads zero
        wr(8'h01, 16'hffff);
        rd(8'h01, 16'h0000);
        $display("test offsets done");
        end_sim();
    end
endmodule

`default_nettype wire
